// ---- core/cbp_buffer_ctrl.sv ----
// Control of one CAN transmit buffer pair with its payload words.
// Assumes the protocol engine and DMA run on aclk; AXI4-Lite master on aclk.
//
// Implementation choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps

module cbp_buffer_ctrl (
  // Clock, reset and clock enable.
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 ce,
  // AXI4-Lite write address and data.
  input  wire logic                 awvalid,
  output logic                      awready,
  input  wire logic [3:0]           awaddr,
  input  wire logic                 wvalid,
  output logic                      wready,
  input  wire logic [31:0]          wdata,
  input  wire logic [3:0]           wstrb,
  // AXI4-Lite write response.
  output logic                      bvalid,
  input  wire logic                 bready,
  output logic [1:0]                bresp,
  // AXI4-Lite read.
  input  wire logic                 arvalid,
  output logic                      arready,
  input  wire logic [3:0]           araddr,
  output logic                      rvalid,
  input  wire logic                 rready,
  output logic [31:0]               rdata,
  output logic [1:0]                rresp,
  // DMA RAM port for payload words.
  input  wire logic                 dma_en,
  input  wire logic                 dma_we,
  input  wire logic [1:0]           dma_addr,
  input  wire logic [1:0]           dma_be,
  input  wire logic [15:0]          dma_wdata,
  output logic [15:0]               dma_rdata,
  // Protocol engine.
  input  wire cbp_pkg::cbp_eng_ev_t eng_ev,
  input  wire logic [1:0]           rtr_hit,
  output cbp_pkg::cbp_sel_t         tx_sel,
  output logic [1:0]                abort_req,
  // Interrupt.
  output logic                      irq
);

  ////////////////////////////////////////////////////////////////////////
  // State.

  cbp_pkg::cbp_ctrl_t ctrl [cbp_pkg::NBUF];
  cbp_pkg::cbp_ctrl_t next_ctrl [cbp_pkg::NBUF];
  logic [15:0]        ram [cbp_pkg::NBUF * cbp_pkg::NWORD];
  logic [3:0]         stat;
  logic [3:0]         mask;
  logic               aw_full;
  logic               w_full;
  logic [3:0]         aw_addr;
  logic [31:0]        w_data;
  logic [3:0]         w_strb;
  logic [1:0]         done_hit;
  logic [1:0]         err_hit;
  logic [1:0]         abort_hit;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode.

  // A write fires once both halves are held and no response is pending.
  wire       do_wr      = aw_full && w_full && !bvalid;
  wire       wr_ctrl    = do_wr && (aw_addr == cbp_pkg::ADDR_CTRL);
  wire       wr_mask    = do_wr && (aw_addr == cbp_pkg::ADDR_MASK);
  wire       wr_stat    = do_wr && (aw_addr == cbp_pkg::ADDR_STAT);
  wire       wr_hit     = wr_ctrl || wr_mask || wr_stat;
  wire       rd_take    = arvalid && arready;
  wire       rd_ctrl    = araddr == cbp_pkg::ADDR_CTRL;
  wire       rd_stat    = araddr == cbp_pkg::ADDR_STAT;
  wire       rd_mask    = araddr == cbp_pkg::ADDR_MASK;
  wire       rd_hit     = rd_ctrl || rd_stat || rd_mask;
  // A status read clears the sticky bits it returns.
  wire       stat_clr   = rd_take && rd_stat;
  wire [15:0] ctrl_word = {ctrl[1], ctrl[0]};

  // Read data selected from the addressed register; unmapped reads as zero.
  wire [31:0] rd_mux =
    rd_ctrl ? {16'h0000, ctrl_word} :
    rd_stat ? {28'h0000000, stat} :
    rd_mask ? {28'h0000000, mask} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////////
  // Per-buffer control byte.

  genvar gi;
  generate
    for (gi = 0; gi < cbp_pkg::NBUF; gi++)
    begin : g_buf
      wire                cur_sel  = eng_ev.buf_idx == 1'(gi);
      wire                sw_wr    = wr_ctrl && w_strb[gi];
      cbp_pkg::cbp_ctrl_t wb;
      assign wb = w_data[gi*8 +: 8];
      wire                sw_set   = sw_wr && wb.send_request && !ctrl[gi].send_request;
      wire                sw_abort = sw_wr && !wb.send_request && ctrl[gi].send_request;
      // A remote frame re-queues the buffer only with auto reply enabled.
      wire                rtr_set  = rtr_hit[gi] && ctrl[gi].auto_remote_reply_enable;
      wire                rise     = (sw_set || rtr_set) && !ctrl[gi].send_request;
      wire                done     = eng_ev.done && cur_sel && ctrl[gi].send_request;
      wire                berr     = eng_ev.bus_error && cur_sel && ctrl[gi].send_request;
      wire                larb     = eng_ev.lost_arb && cur_sel && ctrl[gi].send_request;

      // Next control byte; a set of the request wins over any clear.
      always_comb
      begin
        next_ctrl[gi] = ctrl[gi];
        if (sw_wr)
        begin
          next_ctrl[gi].tx_enable = wb.tx_enable;
          next_ctrl[gi].auto_remote_reply_enable = wb.auto_remote_reply_enable;
          next_ctrl[gi].tx_priority_field = wb.tx_priority_field;
        end
        if (sw_set || rtr_set)
          next_ctrl[gi].send_request = 1'b1;
        else if (done || sw_abort)
          next_ctrl[gi].send_request = 1'b0;
        if (berr)
          next_ctrl[gi].tx_bus_error_flag = 1'b1;
        if (larb)
          next_ctrl[gi].lost_arbitration_flag = 1'b1;
        if (sw_abort)
          next_ctrl[gi].aborted_flag = 1'b1;
        if (rise)
        begin
          next_ctrl[gi].tx_bus_error_flag = 1'b0;
          next_ctrl[gi].aborted_flag = 1'b0;
          next_ctrl[gi].lost_arbitration_flag = 1'b0;
        end
      end

      assign done_hit[gi] = done;
      assign err_hit[gi] = berr;
      assign abort_hit[gi] = sw_abort;

      // Control register, cleared by reset.
      always_ff @(posedge aclk)
      begin
        if (!aresetn)
          ctrl[gi] <= cbp_pkg::CTRL_RESET;
        else if (ce)
          ctrl[gi] <= next_ctrl[gi];
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Transmit selection.

  // Pending buffers are those enabled for transmit with a request set.
  wire [1:0] pend = {ctrl[1].tx_enable && ctrl[1].send_request,
                     ctrl[0].tx_enable && ctrl[0].send_request};
  // Higher priority code wins; a tie goes to buffer 0.
  wire       pick = pend[1] &&
                    (!pend[0] || ctrl[1].tx_priority_field > ctrl[0].tx_priority_field);
  wire [31:0] pick_payload = {ram[{pick, 1'b1}], ram[{pick, 1'b0}]};

  // Offer registered so the engine sees a stable frame.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_sel <= '0;
      abort_req <= 2'h0;
    end
    else if (ce)
    begin
      tx_sel.valid <= |pend;
      tx_sel.buf_idx <= pick;
      tx_sel.payload <= pick_payload;
      abort_req <= abort_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Payload words in DMA RAM: word 4 then word 5 of each buffer.

  // Byte lanes: word 4 holds bytes 2 and 3, word 5 holds bytes 4 and 5.
  wire dma_lo = dma_en && dma_we && dma_be[0];
  wire dma_hi = dma_en && dma_we && dma_be[1];

  // Payload is not reset and stays undefined until written.
  always_ff @(posedge aclk)
  begin
    if (ce)
    begin
      if (dma_lo)
        ram[dma_addr][7:0] <= dma_wdata[7:0];
      if (dma_hi)
        ram[dma_addr][15:8] <= dma_wdata[15:8];
    end
  end

  // Registered DMA read data.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      dma_rdata <= 16'h0000;
    else if (ce && dma_en && !dma_we)
      dma_rdata <= ram[dma_addr];
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status and mask.

  wire [3:0] stat_set = {err_hit, done_hit};
  wire [3:0] next_stat = (stat & ~(stat_clr ? 4'hf : 4'h0)) | stat_set;

  // Sticky events; a new event in the clearing read stays set.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      stat <= cbp_pkg::STAT_RESET;
      mask <= cbp_pkg::MASK_RESET;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      stat <= next_stat;
      if (wr_mask)
        mask <= w_data[3:0];
      irq <= |(next_stat & (wr_mask ? w_data[3:0] : mask));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channels.

  // Address and data are taken independently, then answered together.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready <= 1'b0;
      wready <= 1'b0;
      aw_full <= 1'b0;
      w_full <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= cbp_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (awvalid && awready)
      begin
        aw_addr <= awaddr;
        aw_full <= 1'b1;
        awready <= 1'b0;
      end
      else if (!aw_full && !bvalid)
        awready <= 1'b1;
      if (wvalid && wready)
      begin
        w_data <= wdata;
        w_strb <= wstrb;
        w_full <= 1'b1;
        wready <= 1'b0;
      end
      else if (!w_full && !bvalid)
        wready <= 1'b1;
      if (do_wr)
      begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        bvalid <= 1'b1;
        bresp <= wr_hit ? cbp_pkg::RESP_OKAY : cbp_pkg::RESP_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel.

  // One read at a time; data is captured when the address is taken.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= cbp_pkg::RESP_OKAY;
    end
    else if (ce)
    begin
      if (rd_take)
      begin
        arready <= 1'b0;
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? cbp_pkg::RESP_OKAY : cbp_pkg::RESP_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
      else if (!rvalid)
        arready <= 1'b1;
    end
  end

endmodule

// ---- core/cbp_pkg.sv ----
// Package for the CAN transmit buffer pair control block.
// Assumes one 40 MHz clock domain shared by bus slave, engine and DMA RAM.
package cbp_pkg;

  // Number of buffers in one pair, and payload words kept per buffer.
  localparam int unsigned NBUF = 2;
  localparam int unsigned NWORD = 2;

  // Register byte addresses on the AXI4-Lite slave.
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STAT = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;

  // Values after reset.
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [3:0] STAT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // Positions of the interrupt status fields.
  localparam int unsigned STAT_DONE_POS = 0;
  localparam int unsigned STAT_ERR_POS = 2;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // One buffer's control byte, bit 7 down to bit 0.
  typedef struct packed {
    logic       tx_enable;
    logic       aborted_flag;
    logic       lost_arbitration_flag;
    logic       tx_bus_error_flag;
    logic       send_request;
    logic       auto_remote_reply_enable;
    logic [1:0] tx_priority_field;
  } cbp_ctrl_t;

  // Report from the protocol engine about the buffer it is sending.
  typedef struct packed {
    logic buf_idx;
    logic done;
    logic bus_error;
    logic lost_arb;
  } cbp_eng_ev_t;

  // Frame offered to the protocol engine.
  typedef struct packed {
    logic        valid;
    logic        buf_idx;
    logic [31:0] payload;
  } cbp_sel_t;

endpackage

// ---- testbench/cbp_buffer_ctrl_asserts.sv ----
// Checker for the CAN buffer pair control block, watching its ports.
// Assumes ce is high whenever a bus transfer or engine event is under way.
`timescale 1ns/1ps
module cbp_buffer_ctrl_asserts (
  // Clock and reset.
  input wire logic                 aclk,
  input wire logic                 aresetn,
  // Register bus.
  input wire logic                 awvalid,
  input wire logic                 awready,
  input wire logic                 wvalid,
  input wire logic                 wready,
  input wire logic                 bvalid,
  input wire logic                 bready,
  input wire logic                 arvalid,
  input wire logic                 arready,
  input wire logic                 rvalid,
  input wire logic                 rready,
  input wire logic [31:0]          rdata,
  // Payload port, engine and interrupt.
  input wire logic                 dma_en,
  input wire logic                 dma_we,
  input wire logic [15:0]          dma_rdata,
  input wire cbp_pkg::cbp_eng_ev_t eng_ev,
  input wire logic [1:0]           abort_req,
  input wire logic                 irq
);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // A write taken whole, then its answer two edges on.
  sequence s_wtake;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_wans;
    !awready && !wready ##1 bvalid;
  endsequence
  AST_RST_QUIET: assert property ($rose(aresetn) |-> !bvalid && !rvalid && !irq && !abort_req)
    else $error("outputs busy after reset");
  AST_WR_ANSWER: assert property (s_wtake |=> s_wans)
    else $error("write answer late");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  AST_RD_ANSWER: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  AST_DMA_HOLD: assert property (!(dma_en && !dma_we) |=> $stable(dma_rdata))
    else $error("payload read data moved");
  AST_ABORT_PULSE: assert property (abort_req != 2'h0 |=> abort_req == 2'h0)
    else $error("abort pulse too long");
  AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(eng_ev.done || eng_ev.bus_error) ||
    bvalid || $past(bvalid))
    else $error("interrupt without cause");
endmodule
////////////////////////////////////////////////////////////////////////////////
bind cbp_buffer_ctrl cbp_buffer_ctrl_asserts cbp_buffer_ctrl_asserts_i (.aclk(aclk),
  .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid),
  .rready(rready), .rdata(rdata), .dma_en(dma_en), .dma_we(dma_we), .dma_rdata(dma_rdata),
  .eng_ev(eng_ev), .abort_req(abort_req), .irq(irq));

// ---- testbench/cbp_node_model.sv ----
// Model of the engine and remote nodes facing the buffer pair block.
// Assumes one clock; the bench sets error mode and remote frame pulses.
`timescale 1ns/1ps
module cbp_node_model #(
  parameter int DLY = 20
) (
  // Clock and reset.
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // Bench controls.
  input  wire logic              err_mode,
  input  wire logic [1:0]        rtr_req,
  // Block side.
  input  wire cbp_pkg::cbp_sel_t tx_sel,
  output cbp_pkg::cbp_eng_ev_t   eng_ev,
  output logic [1:0]             rtr_hit,
  output logic [31:0]            seen
);
  logic [7:0] cnt;
  logic       tried;
  // An offered frame goes out DLY+1 cycles after it is first seen, first failing once in error mode.
  always_ff @(posedge aclk)
  begin
    eng_ev <= '0;
    rtr_hit <= rtr_req;
    if (!aresetn || !tx_sel.valid)
    begin
      cnt <= 8'h0;
      tried <= 1'b0;
    end
    else if (cnt == DLY[7:0])
    begin
      cnt <= 8'h0;
      eng_ev.buf_idx <= tx_sel.buf_idx;
      eng_ev.bus_error <= err_mode && !tried;
      eng_ev.done <= !(err_mode && !tried);
      tried <= 1'b1;
      seen <= tx_sel.payload;
    end
    else
      cnt <= cnt + 8'h1;
  end
endmodule

// ---- testbench/testbench.sv ----
// Self-checking bench for the CAN buffer pair control block.
// Assumes the node model and the bound checker are compiled before it.
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    comparisons++; \
    if ((g) !== (e)) \
    begin \
      err_total++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
    end \
  end
module testbench;
  localparam logic [3:0] CT = cbp_pkg::ADDR_CTRL, ST = cbp_pkg::ADDR_STAT, MK = cbp_pkg::ADDR_MASK;
  localparam logic [1:0] OK = cbp_pkg::RESP_OKAY, SE = cbp_pkg::RESP_SLVERR;
  logic        aclk = 1'b0, aresetn = 1'b0, ce = 1'b1, err_mode = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b0, rready = 1'b0;
  logic        dma_en = 1'b0, dma_we = 1'b0, awready, wready, bvalid, arready, rvalid, irq;
  logic [3:0]  awaddr = 4'h0, araddr = 4'h0, wstrb = 4'hf;
  logic [1:0]  dma_addr = 2'h0, dma_be = 2'h3, rtr_req = 2'h0, bresp, rresp, abort_req, rtr_hit;
  logic [15:0] dma_wdata = 16'h0, dma_rdata;
  logic [31:0] wdata = 32'h0, rdata, seen;
  int          err_total = 0, comparisons = 0, aborts = 0;
  cbp_pkg::cbp_eng_ev_t eng_ev;
  cbp_pkg::cbp_sel_t    tx_sel;
  // Clock of 25 ns period.
  always #12.5 aclk = ~aclk;
  // Count abort pulses of buffer 0.
  always @(posedge aclk)
    if (abort_req[0] === 1'b1) aborts <= aborts + 1;
  cbp_buffer_ctrl cbp_buffer_ctrl_i (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .dma_en(dma_en), .dma_we(dma_we), .dma_addr(dma_addr), .dma_be(dma_be),
    .dma_wdata(dma_wdata), .dma_rdata(dma_rdata), .eng_ev(eng_ev), .rtr_hit(rtr_hit),
    .tx_sel(tx_sel), .abort_req(abort_req), .irq(irq));
  cbp_node_model cbp_node_model_i (.aclk(aclk), .aresetn(aresetn), .err_mode(err_mode),
    .rtr_req(rtr_req), .tx_sel(tx_sel), .eng_ev(eng_ev), .rtr_hit(rtr_hit), .seen(seen));
  //////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run.
  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // A wait that ran out ends the run.
  task automatic tmo(input bit t);
    if (t)
    begin
      err_total++;
      stop_test();
    end
  endtask
  // One AXI write; bready is raised only once the answer shows.
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r = OK);
    int n;
    bit fin;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
      fin = bready && bvalid === 1'b1;
      if (bvalid === 1'b1 && !fin) bready <= 1'b1;
      n++;
    end while (!fin && n < 50);
    tmo(n >= 50);
    bready <= 1'b0;
    `CHK("bresp", r, bresp)
  endtask
  // One AXI read compared with what is expected.
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e, input logic [1:0] r = OK);
    int n;
    bit fin;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
      fin = rready && rvalid === 1'b1;
      if (rvalid === 1'b1 && !fin) rready <= 1'b1;
      n++;
    end while (!fin && n < 50);
    tmo(n >= 50);
    rready <= 1'b0;
    `CHK("rdata", e, rdata)
    `CHK("rresp", r, rresp)
  endtask
  // One payload access; read data is settled on return.
  task automatic dma(input logic we, input logic [1:0] ad, input logic [1:0] be,
    input logic [15:0] d);
    dma_en <= 1'b1;
    dma_we <= we;
    dma_addr <= ad;
    dma_be <= be;
    dma_wdata <= d;
    @(posedge aclk);
    dma_en <= 1'b0;
    @(posedge aclk);
  endtask
  // Waits until no frame is offered.
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      @(posedge aclk);
      n++;
    end while (tx_sel.valid !== 1'b0 && n < 200);
    tmo(n >= 200);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Reset values and the unmapped address.
  task automatic t_regs();
    rd_chk(CT, {16'h0, {2{cbp_pkg::CTRL_RESET}}});
    rd_chk(ST, {28'h0, cbp_pkg::STAT_RESET});
    rd_chk(MK, {28'h0, cbp_pkg::MASK_RESET});
    rd_chk(4'hc, 32'h0, SE);
    axi_wr(4'hc, 32'hffff, SE);
    rd_chk(CT, 32'h0);
  endtask
  // Payload bytes reach the frame; interrupt masked, unmasked, cleared.
  task automatic t_payload();
    dma(1'b1, 2'h0, 2'h3, 16'h3322);
    dma(1'b1, 2'h1, 2'h3, 16'h5544);
    dma(1'b1, 2'h0, 2'h1, 16'hffaa);
    dma(1'b0, 2'h0, 2'h0, 16'h0);
    `CHK("word4", 16'h33aa, dma_rdata)
    // A write while the clock enable is low must leave the payload untouched.
    ce <= 1'b0;
    dma(1'b1, 2'h0, 2'h3, 16'h0000);
    ce <= 1'b1;
    dma(1'b0, 2'h0, 2'h0, 16'h0);
    `CHK("word4 frozen", 16'h33aa, dma_rdata)
    axi_wr(CT, 32'h88);
    wait_idle();
    `CHK("payload", 32'h554433aa, seen)
    `CHK("irq masked", 1'b0, irq)
    axi_wr(MK, 32'h5);
    @(posedge aclk);
    `CHK("irq", 1'b1, irq)
    rd_chk(CT, 32'h80);
    rd_chk(ST, 32'h1);
    `CHK("irq cleared", 1'b0, irq)
  endtask
  // Bus error on the first attempt, flag cleared by a new request.
  task automatic t_error();
    err_mode <= 1'b1;
    axi_wr(CT, 32'h88);
    wait_idle();
    err_mode <= 1'b0;
    rd_chk(CT, 32'h90);
    rd_chk(ST, 32'h5);
    axi_wr(CT, 32'h88);
    rd_chk(CT, 32'h88);
    wait_idle();
    rd_chk(CT, 32'h80);
    rd_chk(ST, 32'h1);
  endtask
  // Software abort of a pending request, then a fresh request.
  task automatic t_abort();
    axi_wr(CT, 32'h88);
    axi_wr(CT, 32'h80);
    rd_chk(CT, 32'hc0);
    `CHK("aborts", 1, aborts)
    axi_wr(CT, 32'h88);
    rd_chk(CT, 32'h88);
    wait_idle();
    rd_chk(ST, 32'h1);
  endtask
  // Remote frames on both buffers, auto reply on buffer 0 only.
  task automatic t_remote();
    axi_wr(CT, 32'h8084);
    rtr_req <= 2'h3;
    @(posedge aclk);
    rtr_req <= 2'h0;
    repeat (2) @(posedge aclk);
    rd_chk(CT, 32'h808c);
    wait_idle();
    rd_chk(ST, 32'h1);
  endtask
  // Both buffers pending with four pairs of priority codes, one of them a tie.
  task automatic t_prio();
    logic [3:0] tab [4] = '{4'hb, 4'h9, 4'h0, 4'hc};
    logic       win [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      axi_wr(CT, {16'h0, 6'h22, tab[i][3:2], 6'h22, tab[i][1:0]});
      @(posedge aclk);
      `CHK("winner", win[i], tx_sel.buf_idx)
      wait_idle();
      rd_chk(ST, 32'h3);
    end
  endtask
  // Main sequence.
  initial
  begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_payload();
    t_error();
    t_abort();
    t_remote();
    t_prio();
    stop_test();
  end
endmodule
